// *** hdl/rra_access_path.sv ***
// Address decoder, write buffer and register-access path of the shared bus.
// Assumes targets and masters run on mclk; strap pins are asynchronous.
//
// Summary of operation
// - One buffered register write; a further write stalls until it finishes.
// - Register reads stall the master until data returns.
// - A read after a write waits until the buffered write is done.
// - 0x70xxxxxx decodes to fast local registers.
// - 0x71xxxxxx goes to the switch-core register bus, about 1 us.
// - Organisation and queue targets complete in about 0.1 us.
// - Flash-region reads become flash reads through the boot controller.
// - Flash region is read-only; writes are refused.
// - DRAM-region accesses go to the DRAM controller.
// - PCIe-region accesses become outbound PCIe requests.
// - Reset vector is physical 0; auto boot runs from flash byte 0.
// - Big-endian CPU data is byte-swapped entering and leaving the CPU.
// - Same normal core target: later master waits, round robin; fast exempt.
// - CPU and PCIe core accesses share one serialised core access path.
// - Inbound PCIe is handled on the shared bus like CPU requests.
// - External slave ports use the core bus directly.
// - Serial slave works only while the serial pins belong to it.
// - Two interrupt sources drive CPU interrupt inputs 0 and 1.
// - Default strict priority, CPU highest, programmable per master.
// - With tokens enabled, token holders beat others; priority breaks ties.
`timescale 1ns/1ps
module rra_access_path
   import rra_pkg::*;
#(
   parameter int NM = 3
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic [NM-1:0]       mReq,
   input  wire logic [NM-1:0]       mWe,
   input  wire logic [NM*32-1:0]    mAddr,
   input  wire logic [NM*32-1:0]    mWdata,
   output logic [NM-1:0]            mDone_r,
   output logic                     mErr_r,
   output logic [31:0]              mRdata_r,
   input  wire logic [NM*PRI_W-1:0] plPri,
   input  wire logic                wtEn,
   input  wire logic [TOK_W-1:0]    wtTcl,
   input  wire logic [NM*TOK_W-1:0] wtWeight,
   input  wire logic                bootModePin,
   input  wire logic                bigEndPin,
   input  wire logic                siOwnerPin,
   input  wire logic [1:0]          irqSrc,
   output logic [1:0]               cpuIrq_r,
   output logic [31:0]              cpuBootVec_r,
   output logic [NT-1:0]            tReq_r,
   output logic                     tWe_r,
   output logic [31:0]              tAddr_r,
   output logic [31:0]              tWdata_r,
   input  wire logic [NT-1:0]       tAck,
   input  wire logic [NT*32-1:0]    tRdata,
   output logic                     csReq_r,
   output logic                     csWe_r,
   output logic [23:0]              csAddr_r,
   output logic [31:0]              csWdata_r,
   output logic                     csFast_r,
   input  wire logic                csAck,
   input  wire logic [31:0]         csRdata,
   input  wire logic                extReq,
   input  wire logic                extSerial,
   input  wire logic                extWe,
   input  wire logic [23:0]         extAddr,
   input  wire logic [31:0]         extWdata,
   output logic                     extDone_r,
   output logic                     extErr_r,
   output logic [31:0]              extRdata_r
);

   localparam int MW = $clog2(NM);

   if (NM < 2 || NM > 4) begin : g_badNm
      $error("rra_access_path: NM must be 2..4");
   end

   function automatic logic [31:0] bswap(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   function automatic logic isFast(input logic [23:0] a);
      return a[23:16] == FAST_ORG_ID || a[23:16] == FAST_QUEUE_ID;
   endfunction

   // ----------------------------------------------------------------
   // Strap synchronisers
   // ----------------------------------------------------------------
   logic [2:0] strapMeta_r;
   logic [2:0] strapSync_r;
   logic       bootMode;
   logic       bigEnd;
   logic       siOwner;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta_r <= '0;
         strapSync_r <= '0;
      end else begin
         strapMeta_r <= {siOwnerPin, bigEndPin, bootModePin};
         strapSync_r <= strapMeta_r;
      end
   end

   assign bootMode = strapSync_r[0];
   assign bigEnd   = strapSync_r[1];
   assign siOwner  = strapSync_r[2];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cpuIrq_r     <= '0;
         cpuBootVec_r <= '0;
      end else begin
         cpuIrq_r     <= irqSrc;
         cpuBootVec_r <= BOOT_VECTOR;
      end
   end

   // ----------------------------------------------------------------
   // Shared-bus arbitration
   // ----------------------------------------------------------------
   rra_state_t    st_r;
   logic [MW-1:0] owner_r;
   logic [MW-1:0] gntIdx;
   logic          gntValid;
   logic [NM-1:0] useVec;

   // CPU and inbound PCIe are peers on the shared bus
   rra_sba_arb #(.NM(NM)) u_arb (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .req      (mReq & ~mDone_r),
      .pri      (plPri),
      .wtEn     (wtEn),
      .wtTcl    (wtTcl),
      .wtWeight (wtWeight),
      .useVec   (useVec),
      .gntIdx   (gntIdx),
      .gntValid (gntValid)
   );

   // ----------------------------------------------------------------
   // Decode of the granted request
   // ----------------------------------------------------------------
   logic        ownBuf_r;
   logic        wbValid_r;
   logic        wbWe_r;
   logic [31:0] wbAddr_r;
   logic [31:0] wbData_r;

   wire  [31:0] gAddr    = mAddr[gntIdx*32 +: 32];
   wire         gWe      = mWe[gntIdx];
   wire         gIsCpu   = (gntIdx == MW'(M_CPU));
   wire  [31:0] gWdata   = (gIsCpu && bigEnd) ? bswap(mWdata[gntIdx*32 +: 32])
                                              : mWdata[gntIdx*32 +: 32];
   wire  [3:0]  gRgn     = gAddr[31:28];
   wire         gBoot    = gRgn >= RGN_BOOT && gRgn <= RGN_BOOT3;
   wire         gFlash   = gRgn == RGN_FLASH || (gBoot && bootMode);
   wire         gDram    = (gRgn >= RGN_DRAM && gRgn <= RGN_DRAM3)
                           || (gBoot && !bootMode);
   wire         gPcie    = gRgn >= RGN_PCIE;
   wire         gLocal   = gAddr[31:24] == SUB_LOCAL;
   wire         gCore    = gAddr[31:24] == SUB_CORE;
   wire         gChip    = gLocal || gCore;
   // Unmapped space and flash writes end at once with an error
   wire         gRefuse  = !(gFlash || gDram || gPcie || gChip) || (gFlash && gWe);
   wire  [1:0]  gLane    = gFlash ? 2'(T_FLASH) : gDram ? 2'(T_DRAM)
                         : gPcie ? 2'(T_PCIE) : 2'(T_LOCAL);

   assign useVec = (st_r != ST_IDLE && !ownBuf_r) ? NM'(1) << owner_r : '0;

   // ----------------------------------------------------------------
   // Main access state machine
   // ----------------------------------------------------------------
   logic              intReq_r;
   logic              coreDone_r;
   logic              coreErr_r;
   logic [31:0]       coreData_r;
   logic [TMO_W-1:0]  tCnt_r;
   logic [1:0]        lane_r;

   wire        laneAck  = tAck[lane_r];
   wire [31:0] laneData = tRdata[lane_r*32 +: 32];
   wire        tTmo     = lane_r == 2'(T_LOCAL) && tCnt_r == TMO_W'(LOCAL_TMO_CYC);
   wire        ownCpuBe = owner_r == MW'(M_CPU) && bigEnd;

   task automatic finish(input logic err, input logic [31:0] d);
      if (ownBuf_r) begin
         wbValid_r <= 1'b0;
      end else begin
         mDone_r[owner_r] <= 1'b1;
         mErr_r           <= err;
         mRdata_r         <= ownCpuBe ? bswap(d) : d;
      end
      tReq_r   <= '0;
      intReq_r <= 1'b0;
      st_r     <= ST_DONE;
   endtask

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= ST_IDLE;
         owner_r   <= '0;
         ownBuf_r  <= 1'b0;
         wbValid_r <= 1'b0;
         wbWe_r    <= 1'b0;
         wbAddr_r  <= '0;
         wbData_r  <= '0;
         tReq_r    <= '0;
         tWe_r     <= 1'b0;
         tAddr_r   <= '0;
         tWdata_r  <= '0;
         lane_r    <= '0;
         tCnt_r    <= '0;
         intReq_r  <= 1'b0;
         mDone_r   <= '0;
         mErr_r    <= 1'b0;
         mRdata_r  <= '0;
      end else begin
         mDone_r <= '0;
         tCnt_r  <= (st_r == ST_TGT) ? tCnt_r + 1'b1 : '0;
         case (st_r)
            ST_IDLE: begin
               if (wbValid_r) begin
                  // Drain first, so a following read sees the write done
                  ownBuf_r <= 1'b1;
                  tWe_r    <= 1'b1;
                  tAddr_r  <= wbAddr_r;
                  tWdata_r <= wbData_r;
                  lane_r   <= 2'(T_LOCAL);
                  if (wbAddr_r[31:24] == SUB_CORE) begin
                     intReq_r <= 1'b1;
                     st_r     <= ST_CORE;
                  end else begin
                     tReq_r[T_LOCAL] <= 1'b1;
                     st_r            <= ST_TGT;
                  end
               end else if (gntValid) begin
                  owner_r  <= gntIdx;
                  ownBuf_r <= 1'b0;
                  tWe_r    <= gWe;
                  tAddr_r  <= gAddr;
                  tWdata_r <= gWdata;
                  lane_r   <= gLane;
                  if (gRefuse) begin
                     mDone_r[gntIdx] <= 1'b1;
                     mErr_r          <= 1'b1;
                     mRdata_r        <= ERR_DATA;
                     st_r            <= ST_DONE;
                  end else if (gChip && gWe) begin
                     wbValid_r       <= 1'b1;
                     wbWe_r          <= 1'b1;
                     wbAddr_r        <= gAddr;
                     wbData_r        <= gWdata;
                     mDone_r[gntIdx] <= 1'b1;
                     mErr_r          <= 1'b0;
                     st_r            <= ST_DONE;
                  end else if (gCore) begin
                     intReq_r <= 1'b1;
                     st_r     <= ST_CORE;
                  end else begin
                     tReq_r[gLane] <= 1'b1;
                     st_r          <= ST_TGT;
                  end
               end
            end
            ST_TGT: begin
               if (laneAck) begin
                  finish(1'b0, laneData);
               end else if (tTmo) begin
                  finish(1'b1, ERR_DATA);
               end
            end
            ST_CORE: begin
               if (coreDone_r) begin
                  finish(coreErr_r, coreData_r);
               end
            end
            ST_DONE: begin
               // Gap cycle lets the master drop its request after the done pulse
               st_r <= ST_IDLE;
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Switch-core register bus lane, shared with the external slaves
   // ----------------------------------------------------------------
   logic             csOwnExt_r;
   logic             rrExt_r;
   logic             csGap_r;
   logic [TMO_W-1:0] csCnt_r;

   // Serial slave requests only count while the serial pins are its own
   wire extOk   = extReq && (!extSerial || siOwner) && !extDone_r;
   wire intOk   = intReq_r && !coreDone_r;
   wire extFast = isFast(extAddr);
   wire intFast = isFast(tAddr_r[23:0]);
   // Fast targets are not part of the round robin; internal goes first
   wire pickExt = extOk && (!intOk || (rrExt_r && !intFast && !extFast));
   wire csTmo   = csCnt_r == (csFast_r ? TMO_W'(FAST_TMO_CYC)
                                       : TMO_W'(CORE_TMO_CYC));
   wire csEnd   = csReq_r && (csAck || csTmo);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         csReq_r    <= 1'b0;
         csWe_r     <= 1'b0;
         csAddr_r   <= '0;
         csWdata_r  <= '0;
         csFast_r   <= 1'b0;
         csOwnExt_r <= 1'b0;
         rrExt_r    <= 1'b0;
         csGap_r    <= 1'b0;
         csCnt_r    <= '0;
         coreDone_r <= 1'b0;
         coreErr_r  <= 1'b0;
         coreData_r <= '0;
         extDone_r  <= 1'b0;
         extErr_r   <= 1'b0;
         extRdata_r <= '0;
      end else begin
         coreDone_r <= 1'b0;
         extDone_r  <= 1'b0;
         csGap_r    <= 1'b0;
         csCnt_r    <= csReq_r ? csCnt_r + 1'b1 : '0;
         if (csEnd) begin
            csReq_r <= 1'b0;
            csGap_r <= 1'b1;
            if (csOwnExt_r) begin
               extDone_r  <= 1'b1;
               extErr_r   <= !csAck;
               extRdata_r <= csAck ? csRdata : ERR_DATA;
            end else begin
               coreDone_r <= 1'b1;
               coreErr_r  <= !csAck;
               coreData_r <= csAck ? csRdata : ERR_DATA;
            end
         end else if (!csReq_r && !csGap_r && (extOk || intOk)) begin
            csReq_r    <= 1'b1;
            csOwnExt_r <= pickExt;
            csWe_r     <= pickExt ? extWe : tWe_r;
            csAddr_r   <= pickExt ? extAddr : tAddr_r[23:0];
            csWdata_r  <= pickExt ? extWdata : tWdata_r;
            csFast_r   <= pickExt ? extFast : intFast;
            if (extOk && intOk && !intFast && !extFast) begin
               rrExt_r <= !pickExt;
            end
         end
      end
   end

endmodule

// *** include/rra_pkg.sv ***
// Shared constants for the register-region access path: memory map,
// master indices, target lanes, timing and error values.
// Assumes a single 250 MHz system clock for all users of the package.
package rra_pkg;

   // ----------------------------------------------------------------
   // Masters on the shared bus
   // ----------------------------------------------------------------
   localparam int M_CPU  = 0;
   localparam int M_PCIE = 1;
   localparam int M_SBA  = 2;
   localparam int PRI_W  = 4;
   localparam int TOK_W  = 12;

   // ----------------------------------------------------------------
   // Memory map, decoded on address bits 31:28 and 31:24
   // ----------------------------------------------------------------
   localparam logic [3:0] RGN_BOOT  = 4'h0;
   localparam logic [3:0] RGN_BOOT3 = 4'h3;
   localparam logic [3:0] RGN_FLASH = 4'h4;
   localparam logic [3:0] RGN_CHIP  = 4'h7;
   localparam logic [3:0] RGN_DRAM  = 4'h8;
   localparam logic [3:0] RGN_DRAM3 = 4'hb;
   localparam logic [3:0] RGN_PCIE  = 4'hc;
   localparam logic [7:0] SUB_LOCAL = 8'h70;
   localparam logic [7:0] SUB_CORE  = 8'h71;
   localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;

   // Switch-core target number sits in address bits 23:16
   localparam logic [7:0] FAST_ORG_ID   = 8'h00;
   localparam logic [7:0] FAST_QUEUE_ID = 8'h01;

   // ----------------------------------------------------------------
   // Target lanes of the downstream port
   // ----------------------------------------------------------------
   localparam int NT      = 4;
   localparam int T_LOCAL = 0;
   localparam int T_FLASH = 1;
   localparam int T_DRAM  = 2;
   localparam int T_PCIE  = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ     = 250;
   localparam int CORE_ACC_NS = 1000;
   localparam int FAST_ACC_NS = 100;
   localparam int LOCAL_TMO_CYC = 8;
   // Shared targets may take twice the nominal time before we give up
   localparam int CORE_TMO_CYC = 2 * CORE_ACC_NS * CLK_MHZ / 1000;
   localparam int FAST_TMO_CYC = 2 * FAST_ACC_NS * CLK_MHZ / 1000;
   localparam int TMO_W = 10;

   localparam logic [31:0] ERR_DATA = 32'h8888_8888;

   typedef enum logic [1:0] {ST_IDLE, ST_TGT, ST_CORE, ST_DONE} rra_state_t;

endpackage

// *** hdl/rra_sba_arb.sv ***
// Shared-bus arbiter: strict priority with optional weighted tokens.
// Requests and usage come from logic on the same clock.
`timescale 1ns/1ps
module rra_sba_arb
   import rra_pkg::*;
#(
   parameter int NM = 3
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic [NM-1:0]           req,
   input  wire logic [NM*PRI_W-1:0]     pri,
   input  wire logic                    wtEn,
   input  wire logic [TOK_W-1:0]        wtTcl,
   input  wire logic [NM*TOK_W-1:0]     wtWeight,
   input  wire logic [NM-1:0]           useVec,
   output logic [$clog2(NM)-1:0]        gntIdx,
   output logic                         gntValid
);

   logic [TOK_W-1:0] period_r;
   logic [TOK_W-1:0] tok_r [NM];
   logic [NM-1:0]    hasTok;
   logic             refresh;

   assign refresh = (period_r >= wtTcl);

   // ----------------------------------------------------------------
   // Token bookkeeping; a weight of zero means unlimited tokens
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         period_r <= '0;
      end else begin
         period_r <= refresh ? '0 : period_r + 1'b1;
      end
   end

   for (genvar i = 0; i < NM; i++) begin : g_tok
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            tok_r[i] <= '0;
         end else if (refresh) begin
            tok_r[i] <= wtWeight[i*TOK_W +: TOK_W];
         end else if (useVec[i] && tok_r[i] != '0) begin
            tok_r[i] <= tok_r[i] - 1'b1;
         end
      end
      assign hasTok[i] = !wtEn || wtWeight[i*TOK_W +: TOK_W] == '0 || tok_r[i] != '0;
   end

   // ----------------------------------------------------------------
   // Token holders first, then priority, then lowest index
   // ----------------------------------------------------------------
   always_comb begin
      logic [PRI_W:0] best;
      logic [PRI_W:0] key;
      best     = '0;
      key      = '0;
      gntIdx   = '0;
      gntValid = 1'b0;
      for (int i = 0; i < NM; i++) begin
         key = {hasTok[i], pri[i*PRI_W +: PRI_W]};
         if (req[i] && (!gntValid || key > best)) begin
            best     = key;
            gntIdx   = i[$clog2(NM)-1:0];
            gntValid = 1'b1;
         end
      end
   end

endmodule

// *** test/rra_props.sv ***
// Checker on the access path ports.
// Assumes one clock; targets answer in bounds.
`timescale 1ns/1ps
module rra_props
   import rra_pkg::*;
#(
   parameter int NM = 3
) (
   input logic             mclk,
   input logic             rst_n,
   input logic [NM-1:0]    mReq,
   input logic [NM-1:0]    mWe,
   input logic [NM*32-1:0] mAddr,
   input logic [NM-1:0]    mDone_r,
   input logic             mErr_r,
   input logic [31:0]      mRdata_r,
   input logic [1:0]       irqSrc,
   input logic [1:0]       cpuIrq_r,
   input logic [31:0]      cpuBootVec_r,
   input logic [NT-1:0]    tReq_r,
   input logic             tWe_r,
   input logic [31:0]      tAddr_r,
   input logic [NT-1:0]    tAck,
   input logic             csReq_r,
   input logic [23:0]      csAddr_r,
   input logic             csAck
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire rdLoc = mDone_r[0] && !mWe[0] && mAddr[31:24] == SUB_LOCAL && !mErr_r;
   wire wrFl = mDone_r[0] && mReq[0] && mWe[0] && mAddr[31:28] == RGN_FLASH;
   // ----------
   // Properties
   // ----------
   property p_irq; cpuIrq_r == $past(irqSrc); endproperty
   a_irq: assert property (p_irq) else $error("irq late");
   property p_boot; cpuBootVec_r == BOOT_VECTOR; endproperty
   a_boot: assert property (p_boot) else $error("boot vector");
   property p_oneDone; $onehot0(mDone_r); endproperty
   a_oneDone: assert property (p_oneDone) else $error("two dones");
   property p_tHold; |tReq_r && !(|tAck) |=> $stable(tReq_r) && $stable(tAddr_r); endproperty
   a_tHold: assert property (p_tHold) else $error("lane request dropped");
   property p_csHold; csReq_r && !csAck |=> csReq_r && $stable(csAddr_r); endproperty
   a_csHold: assert property (p_csHold) else $error("core request dropped");
   property p_csBound; $rose(csReq_r) |-> ##[1:501] !csReq_r; endproperty
   a_csBound: assert property (p_csBound) else $error("core access too long");
   property p_flashRo; tReq_r[T_FLASH] |-> !tWe_r; endproperty
   a_flashRo: assert property (p_flashRo) else $error("flash write issued");
   property p_flashErr; wrFl |-> mErr_r && mRdata_r == ERR_DATA; endproperty
   a_flashErr: assert property (p_flashErr) else $error("flash write taken");
   property p_localRd; rdLoc |-> $past(tAck[T_LOCAL]); endproperty
   a_localRd: assert property (p_localRd) else $error("read done early");
   c_core: cover property (csReq_r && csAck);
   c_err: cover property (mDone_r[0] && mErr_r);
   c_drain: cover property (tReq_r[T_LOCAL] && tAck[T_LOCAL] && tWe_r);
endmodule
bind rra_access_path rra_props #(.NM(NM)) rra_props_inst (.mclk, .rst_n, .mReq, .mWe,
   .mAddr, .mDone_r, .mErr_r, .mRdata_r, .irqSrc, .cpuIrq_r, .cpuBootVec_r, .tReq_r,
   .tWe_r, .tAddr_r, .tAck, .csReq_r, .csAddr_r, .csAck);

// *** test/rra_targets.sv ***
// Model of the lane targets and the core register bus.
// Assumes requests held until acknowledged.
`timescale 1ns/1ps
module rra_targets
   import rra_pkg::*;
(
   input  logic             mclk,
   input  logic             rst_n,
   input  logic             slow,
   input  logic [NT-1:0]    tReq_r,
   input  logic             csReq_r,
   input  logic             csFast_r,
   input  logic [23:0]      csAddr_r,
   output logic [NT-1:0]    tAck,
   output logic [NT*32-1:0] tRdata,
   output logic             csAck,
   output logic [31:0]      csRdata
);
   logic [7:0] tCnt_r;
   logic [7:0] csCnt_r;
   // Fast targets answer well inside bound
   wire [7:0] csDly = csFast_r ? 8'h04 : (slow ? 8'h3c : 8'h0a);
   wire [31:0] csPat = {8'h00, csAddr_r} ^ 32'h0f0f_0f0f;
   // Idle data is inverted so stale data never matches
   for (genvar i = 0; i < NT; i++) begin : g_lane
      assign tRdata[i*32+:32] = {32{~tAck[i]}} ^ {28'h5a5a5a5, 4'(i)};
   end
   assign csRdata = {32{~csAck}} ^ csPat;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tCnt_r <= 8'h00;
         csCnt_r <= 8'h00;
         tAck <= '0;
         csAck <= 1'h0;
      end else begin
         tAck <= '0;
         csAck <= 1'h0;
         if (|tReq_r && !(|tAck)) begin
            tCnt_r <= (tCnt_r >= 8'h02) ? 8'h00 : tCnt_r + 8'h01;
            if (tCnt_r >= 8'h02) tAck <= tReq_r;
         end
         if (csReq_r && !csAck) begin
            csCnt_r <= (csCnt_r >= csDly) ? 8'h00 : csCnt_r + 8'h01;
            if (csCnt_r >= csDly) csAck <= 1'h1;
         end
      end
   end
endmodule

// *** test/tb.sv ***
// Bench: scenario tasks for the access path.
// Assumes rra_targets answers all requests.
`timescale 1ns/1ps
module tb;
   import rra_pkg::*;
   logic mclk = 1'h0, rst_n = 1'h0, slow = 1'h0, bigEndPin = 1'h0, siOwnerPin = 1'h0;
   logic [2:0] mReq = '0, mWe = '0, mDone_r;
   logic [95:0] mAddr = '0, mWdata = '0;
   logic [11:0] plPri = 12'h123;
   logic [1:0] irqSrc = 2'h0, cpuIrq_r;
   logic [NT-1:0] tReq_r, tAck;
   logic [NT*32-1:0] tRdata;
   logic [31:0] mRdata_r, cpuBootVec_r, tAddr_r, tWdata_r, csWdata_r, csRdata, wData, rd;
   logic [31:0] extRdata_r, extWdata = '0;
   logic [23:0] csAddr_r, csLast, extAddr = 24'h05_0004;
   logic mErr_r, tWe_r, csReq_r, csWe_r, csFast_r, csAck, csFastSeen, extDone_r, extErr_r;
   logic extReq = 1'h0, extSerial = 1'h0, bootModePin = 1'h0, er;
   int err_count = 0, check_count = 0, wCnt = 0, csWCnt = 0, c;
   rra_access_path #(.NM(3)) rra_access_path_inst (.mclk, .rst_n, .mReq, .mWe, .mAddr,
      .mWdata, .mDone_r, .mErr_r, .mRdata_r, .plPri, .wtEn(1'h0), .wtTcl(12'h000),
      .wtWeight(36'h0), .bootModePin, .bigEndPin, .siOwnerPin, .irqSrc, .cpuIrq_r,
      .cpuBootVec_r, .tReq_r, .tWe_r, .tAddr_r, .tWdata_r, .tAck, .tRdata, .csReq_r, .csWe_r,
      .csAddr_r, .csWdata_r, .csFast_r, .csAck, .csRdata, .extReq, .extSerial,
      .extWe(1'h0), .extAddr, .extWdata, .extDone_r, .extErr_r, .extRdata_r);
   rra_targets rra_targets_inst (.mclk, .rst_n, .slow, .tReq_r, .csReq_r, .csFast_r,
      .csAddr_r, .tAck, .tRdata, .csAck, .csRdata);
   initial forever #2 mclk = ~mclk;
   // ----------
   // Monitors and tasks
   // ----------
   always @(posedge mclk) begin
      if (tReq_r[T_LOCAL] && tAck[T_LOCAL] && tWe_r) begin
         wCnt++;
         wData = tWdata_r;
      end
      if (csReq_r && csAck) begin
         csFastSeen = csFast_r;
         if (csWe_r) begin
            csWCnt++;
            csLast = csAddr_r;
         end
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic access(input int i, input logic we, input logic [31:0] a, d,
                         output logic [31:0] rd, output logic er, output int n);
      @(negedge mclk);
      mReq[i] = 1'h1;
      mWe[i] = we;
      mAddr[i*32+:32] = a;
      mWdata[i*32+:32] = d;
      for (n = 0; n < 2000 && mDone_r[i] !== 1'h1; n++) begin
         @(posedge mclk);
         #1;
      end
      rd = mRdata_r;
      er = mErr_r;
      if (n >= 2000) begin
         err_count++;
         give_verdict();
      end
      @(negedge mclk);
      mReq[i] = 1'h0;
   endtask
   // Refused requests stay up
   task automatic ext_req(input logic ser, input int lim, output int n,
                          output logic [31:0] rd);
      @(negedge mclk);
      extReq = 1'h1;
      extSerial = ser;
      for (n = 0; n < lim && extDone_r !== 1'h1; n++) begin
         @(posedge mclk);
         #1;
      end
      rd = extRdata_r;
      if (n < lim) begin
         @(negedge mclk);
         extReq = 1'h0;
      end
   endtask
   // ----------
   // Scenarios
   // ----------
   task s_local;
      access(0, 1'h1, 32'h7000_0010, 32'h1234_abcd, rd, er, c);
      chk(32'(c), 32'h1);
      access(0, 1'h0, 32'h7000_0010, '0, rd, er, c);
      chk(rd, 32'h5a5a_5a50);
      chk(32'(wCnt), 32'h1);
      chk(wData, 32'h1234_abcd);
      @(negedge mclk) irqSrc = 2'h2;
      repeat (2) @(negedge mclk);
      chk(32'(cpuIrq_r), 32'h2);
      chk(cpuBootVec_r, BOOT_VECTOR);
   endtask
   task s_core;
      slow = 1'h1;
      access(0, 1'h1, 32'h7105_0000, 32'h1, rd, er, c);
      access(0, 1'h1, 32'h7105_0004, 32'h2, rd, er, c);
      chk(32'(c > 40), 32'h1);
      access(0, 1'h0, 32'h7105_0004, '0, rd, er, c);
      chk(rd, 32'h0f0a_0f0b);
      chk(32'(csWCnt), 32'h2);
      chk({8'h00, csLast}, 32'h0005_0004);
      slow = 1'h0;
      access(1, 1'h0, 32'h7100_0008, '0, rd, er, c);
      chk(32'(csFastSeen), 32'h1);
      chk(rd, 32'h0f0f_0f07);
   endtask
   task s_regions;
      logic [31:0] a[3];
      a = '{32'h4000_0100, 32'h8000_0020, 32'hc000_0040};
      for (int k = 0; k < 3; k++) begin
         access(1, 1'h0, a[k], '0, rd, er, c);
         chk(32'(er), 32'h0);
         chk(rd, {28'h5a5a5a5, 4'(k + 1)});
      end
      access(2, 1'h1, 32'h0000_0020, 32'h55aa_0001, rd, er, c);
      chk(32'(er), 32'h0);
      access(0, 1'h1, 32'h4000_0000, 32'h1, rd, er, c);
      chk(32'(er), 32'h1);
      chk(rd, ERR_DATA);
      bigEndPin = 1'h1;
      bootModePin = 1'h1;
      repeat (3) @(negedge mclk);
      access(0, 1'h0, 32'h0000_0100, '0, rd, er, c);
      chk(rd, 32'h515a_5a5a);
      bigEndPin = 1'h0;
   endtask
   task s_arb;
      logic [31:0] r0, r1;
      logic e0, e1;
      int c0, c1;
      for (int k = 0; k < 2; k++) begin
         plPri = k ? 12'h132 : 12'h123;
         fork
            access(0, 1'h0, 32'h7000_0000, '0, r0, e0, c0);
            access(1, 1'h0, 32'h7000_0004, '0, r1, e1, c1);
         join
         chk(32'(c0 < c1), 32'(k == 0));
      end
   endtask
   task s_ext;
      ext_req(1'h0, 600, c, rd);
      chk(rd, 32'h0f0a_0f0b);
      ext_req(1'h1, 40, c, rd);
      chk(32'(c), 32'h28);
      @(negedge mclk) siOwnerPin = 1'h1;
      ext_req(1'h1, 600, c, rd);
      chk(rd, 32'h0f0a_0f0b);
      chk(32'(c < 600), 32'h1);
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      @(negedge mclk) rst_n = 1'h1;
      repeat (3) @(negedge mclk);
      s_local();
      s_core();
      s_regions();
      s_arb();
      s_ext();
      give_verdict();
   end
endmodule
